// ### dv/test_option_config_loader.sv
// Purpose: Self-checking bench for the option configuration loader
// Assumes: Zero-wait slave; short PROG_CYCLES and WATCHDOG_CYCLES
// Notes:   Options are programmed, then made active by a reset
`timescale 1ns/1ps
module test_option_config_loader;
    localparam logic [13:0] PC = ocl_pkg::IDX_PROGRAM_CONTROL;
    logic hclk, hresetn, hsel, hwrite, boot_mode, nv_erase, pv_on, in_rng;
    logic irq_n, stop_exec, wake_event, hreadyout, hresp, wde, wdr, ext;
    logic bo, tick, osc, halt, stp, lock, h, s, o;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] haddr;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0] porta_n, pirq, pen, acc;
    logic [6:0] div;
    int n_mismatch = 0;
    int cmp_count = 0;
    int ne;
    ocl_top #(.PROG_CYCLES(20), .WATCHDOG_CYCLES(16)) DUT (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .boot_mode(boot_mode), .nv_erase(nv_erase),
        .programming_voltage_on(pv_on), .irq_pin_in_logic_range(in_rng),
        .irq_n(irq_n), .porta_n(porta_n), .stop_exec(stop_exec),
        .wake_event(wake_event), .watchdog_enable(wde),
        .watchdog_reset_req(wdr), .ext_irq_req(ext), .porta_irq_req(pirq),
        .porta_pullup_irq_enable(pen), .serial_bit_order_select(bo),
        .serial_div_ratio(div), .serial_clk_tick(tick), .osc_run(osc),
        .halt_mode(halt), .stop_mode(stp), .readout_lock(lock));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Address phase held until hready, then data phase until hready
    task bus(input logic w, input logic [13:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {idx, 2'b00}; hwrite <= w; htrans <= 2'h2;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
        rd = hrdata;
        if (n >= 99) begin n_mismatch++; conclude(); end
    endtask : bus
    task prog(input logic [13:0] idx, input logic [7:0] d);
        // Both bits from a clear register: only the latch may be set
        bus(1'b1, PC, 32'h0000_0005); bus(1'b0, PC, '0);
        chk("control both set", 32'h0000_0004, rd);
        bus(1'b1, idx, {24'h00_0000, d});
        pv_on <= 1'b1; bus(1'b1, PC, 32'h0000_0005); bus(1'b0, PC, '0);
        chk("control voltage on", 32'h0000_0005, rd);
        repeat (25) @(posedge hclk);
        bus(1'b1, PC, 32'h0000_0001); bus(1'b0, PC, '0); pv_on <= 1'b0;
        chk("control latch cleared", 32'h0000_0000, rd);
        bus(1'b0, idx, '0);
        chk("stored byte", {24'h00_0000, d}, rd);
    endtask : prog
    task rst;
        @(posedge hclk); hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : rst
    task erase;
        @(posedge hclk); nv_erase <= 1'b1;
        @(posedge hclk); nv_erase <= 1'b0;
    endtask : erase
    task stop_wake;
        @(posedge hclk); stop_exec <= 1'b1;
        @(posedge hclk); stop_exec <= 1'b0;
        @(posedge hclk); h = halt; s = stp; o = osc; wake_event <= 1'b1;
        @(posedge hclk); wake_event <= 1'b0;
    endtask : stop_wake
    // Holds all pins low and counts requests over twelve cycles
    task sense;
        ne = 0; acc = 8'h00; irq_n <= 1'b0; porta_n <= 8'h00;
        repeat (12) begin @(posedge hclk); ne += ext; acc |= pirq; end
        irq_n <= 1'b1; porta_n <= 8'hff;
        repeat (3) @(posedge hclk);
    endtask : sense
    task ticks;
        ne = 0;
        repeat (64) begin @(posedge hclk); ne += tick; end
    endtask : ticks
    // First edge skipped: a pulse launched before the change is not counted
    task wd_wait;
        ne = 0;
        @(posedge hclk);
        repeat (60) begin @(posedge hclk); ne += wdr; end
    endtask : wd_wait
    initial begin
        hresetn = 0; hsel = 0; haddr = '0; htrans = '0; hwrite = 0;
        hsize = 3'h2; hwdata = '0; boot_mode = 0; nv_erase = 1; pv_on = 0;
        in_rng = 1; irq_n = 1; porta_n = 8'hff; stop_exec = 0; wake_event = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        erase();
        bus(1'b1, PC, 32'h0000_0004); bus(1'b0, PC, '0);
        chk("control outside boot", 32'h0000_0000, rd);
        boot_mode <= 1'b1;
        prog(ocl_pkg::IDX_OPTION_BYTE_ONE, 8'h7d);
        prog(ocl_pkg::IDX_OPTION_BYTE_TWO, 8'ha5);
        bus(1'b0, ocl_pkg::IDX_ACTIVE_OPTIONS, '0);
        chk("active before reset", 32'h0000_0000, rd);
        boot_mode <= 1'b0; rst();
        bus(1'b0, ocl_pkg::IDX_ACTIVE_OPTIONS, '0);
        chk("active after reset", 32'h0000_a57d, rd);
        bus(1'b0, ocl_pkg::IDX_LOADER_STATUS, '0);
        chk("loader status", 32'h0000_0001, rd);
        chk("bus response", 32'h0000_0000, hresp);
        bus(1'b0, 14'h0100, '0); chk("unmapped", 32'h0000_0000, rd);
        chk("lock", 32'h1, lock);
        chk("lsb first", 32'h1, bo);
        chk("divide code 11", 32'h8, div);
        chk("port enables", 32'ha5, pen);
        chk("wd enabled", 32'h0000_0001, wde);
        ticks(); chk("ticks code 11", 32'h0000_0008, ne);
        stop_wake(); chk("halt", 32'h1, h);
        chk("osc kept", 32'h1, o);
        sense(); chk("edge count", 32'h1, ne);
        chk("port requests", 32'ha5, acc);
        in_rng <= 1'b0; wd_wait(); chk("wd out of range", 0, ne);
        in_rng <= 1'b1; wd_wait(); chk("wd fires", 1, ne > 0);
        boot_mode <= 1'b1; erase(); prog(ocl_pkg::IDX_OPTION_BYTE_ONE, 8'h02);
        boot_mode <= 1'b0; rst(); repeat (2) @(posedge hclk);
        chk("wd disabled", 32'h0000_0000, wde);
        ticks(); chk("ticks code 00", 32'h0000_0001, ne);
        chk("msb first", 32'h0, bo);
        chk("divide code 00", 32'h40, div);
        stop_wake(); chk("stop mode", 32'h1, s);
        chk("osc stopped", 32'h0, o);
        sense(); chk("level held", 32'h0000_000b, ne);
        chk("ports disabled", 32'h0, acc);
        pv_on <= 1'b1; wd_wait(); chk("wd off", 0, ne);
        conclude();
    end
endmodule : test_option_config_loader

// ### rtl/ocl_irq_sense.sv
// Purpose: Active-low interrupt input sensing, edge or edge-and-level
// Assumes: Pins are synchronous to hclk
// Notes:   One request flop per pin, disabled pins never request
`timescale 1ns/1ps
module ocl_irq_sense #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] pin_n,
    input wire logic [WIDTH-1:0] enable,
    input wire logic level_mode,
    output logic [WIDTH-1:0] req
);

    typedef struct packed {
        logic [WIDTH-1:0] prev_n;
        logic [WIDTH-1:0] req;
    } ocl_irq_s;

    ocl_irq_s st_q;
    ocl_irq_s st_d;
    logic [WIDTH-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            // Edge always counts; a held low only when level mode is on
            assign hit[gi] = enable[gi] &
                ((st_q.prev_n[gi] & ~pin_n[gi]) |
                 (level_mode & ~pin_n[gi]));
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.prev_n = pin_n;
        st_d.req = hit;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{prev_n: '1, req: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign req = st_q.req;

    property p_edge_only;
        @(posedge hclk) disable iff (!hresetn)
        (!level_mode && !pin_n[0] && !st_q.prev_n[0]) |=> !req[0];
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("held low pin requested in edge mode");

    property p_level_low;
        @(posedge hclk) disable iff (!hresetn)
        (level_mode && enable[0] && !pin_n[0]) |=> req[0];
    endproperty
    a_level_low: assert property (p_level_low)
        else $error("low level missed in level mode");

endmodule : ocl_irq_sense

// ### rtl/ocl_nv_store.sv
// Purpose: Two-byte nonvolatile option store with timed programming
// Assumes: Erased bytes read zero; programming only sets bits
// Notes:   Stored bytes survive hresetn; only the erase input clears them
`timescale 1ns/1ps
module ocl_nv_store #(
    parameter int PROG_CYCLES = ocl_pkg::PROGRAM_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic nv_erase,
    input wire logic capture,
    input wire logic capture_sel_two,
    input wire logic [7:0] capture_data,
    input wire logic latch_on,
    input wire logic prog_on,
    output logic [7:0] byte_one,
    output logic [7:0] byte_two,
    output logic pending,
    output logic busy
);

    typedef struct packed {
        logic [7:0] mem_one;
        logic [7:0] mem_two;
        logic pend_v;
        logic pend_two;
        logic [7:0] pend_data;
        logic [31:0] cnt;
        logic done;
    } ocl_nv_s;

    ocl_nv_s st_q;
    ocl_nv_s st_d;

    always_comb begin
        st_d = st_q;
        if (!latch_on) begin
            st_d.pend_v = 1'b0;
        end else if (capture) begin
            st_d.pend_v = 1'b1;
            st_d.pend_two = capture_sel_two;
            st_d.pend_data = capture_data;
        end
        // Only a held programming pulse of full length commits a byte
        if (!prog_on || !st_q.pend_v) begin
            st_d.cnt = '0;
            st_d.done = 1'b0;
        end else if (!st_q.done) begin
            if (st_q.cnt == 32'(PROG_CYCLES - 1)) begin
                st_d.done = 1'b1;
                st_d.cnt = '0;
                if (st_q.pend_two) begin
                    st_d.mem_two = st_q.mem_two | st_q.pend_data;
                end else begin
                    st_d.mem_one = st_q.mem_one | st_q.pend_data;
                end
            end else begin
                st_d.cnt = st_q.cnt + 32'h0000_0001;
            end
        end
        if (nv_erase) begin
            st_d.mem_one = ocl_pkg::OPT_ERASED;
            st_d.mem_two = ocl_pkg::OPT_ERASED;
        end
    end

    // Array bits take no reset: they must outlive every device reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q.pend_v <= 1'b0;
            st_q.pend_two <= 1'b0;
            st_q.pend_data <= ocl_pkg::OPT_ERASED;
            st_q.cnt <= '0;
            st_q.done <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Bytes read erased while erase is on, so a power-up load sees no unknowns
    assign byte_one = nv_erase ? ocl_pkg::OPT_ERASED : st_q.mem_one;
    assign byte_two = nv_erase ? ocl_pkg::OPT_ERASED : st_q.mem_two;
    assign pending = st_q.pend_v;
    assign busy = prog_on & st_q.pend_v & ~st_q.done;

    property p_commit_time;
        @(posedge hclk) disable iff (!hresetn)
        $rose(st_q.done) |-> $past(st_q.cnt) == 32'(PROG_CYCLES - 1);
    endproperty
    a_commit_time: assert property (p_commit_time)
        else $error("option byte committed before program time");

    property p_mem_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!$past(prog_on) && !$past(nv_erase)) |->
            ($stable(st_q.mem_one) && $stable(st_q.mem_two));
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("option store changed without programming");

endmodule : ocl_nv_store

// ### rtl/ocl_pkg.sv
// Purpose: Shared constants for the option configuration loader
// Assumes: 100 MHz hclk, AHB-Lite register access, word index = byte addr/4
// Notes:   Option bytes are nonvolatile; active copies load at reset
package ocl_pkg;

    // ------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int IDX_W = 14;
    localparam logic [13:0] IDX_PROGRAM_CONTROL = 14'h001c;
    localparam logic [13:0] IDX_OPTION_BYTE_TWO = 14'h1eff;
    localparam logic [13:0] IDX_OPTION_BYTE_ONE = 14'h1f00;
    localparam logic [13:0] IDX_ACTIVE_OPTIONS = 14'h0020;
    localparam logic [13:0] IDX_WATCHDOG_SERVICE = 14'h0021;
    localparam logic [13:0] IDX_LOADER_STATUS = 14'h0022;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PC_VOLTAGE_BIT = 0;
    localparam int PC_LATCH_BIT = 2;
    localparam int OPT_WATCHDOG_BIT = 0;
    localparam int OPT_LEVEL_BIT = 1;
    localparam int OPT_LSB_FIRST_BIT = 2;
    localparam int OPT_RATE_LOW_BIT = 3;
    localparam int OPT_RATE_HIGH_BIT = 4;
    localparam int OPT_STOP_OSC_BIT = 5;
    localparam int OPT_SECURE_BIT = 6;
    localparam int ST_LOADED_BIT = 0;
    localparam int ST_PENDING_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_HALT_BIT = 3;
    localparam int ST_STOP_BIT = 4;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] OPT_ERASED = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [6:0] DIV_RATE_00 = 7'h40;
    localparam logic [6:0] DIV_RATE_01 = 7'h20;
    localparam logic [6:0] DIV_RATE_10 = 7'h10;
    localparam logic [6:0] DIV_RATE_11 = 7'h08;

    typedef enum logic [1:0] {
        OCL_RUN = 2'b00,
        OCL_HALT = 2'b01,
        OCL_STOP = 2'b10
    } ocl_pwr_e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROGRAM_TIME_NS = 4000000;
    localparam int PROGRAM_CYCLES =
        (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WATCHDOG_CYCLES = 65536;

endpackage : ocl_pkg

// ### rtl/ocl_top.sv
// Purpose: Option configuration loader with AHB-Lite register access
// Assumes: Zero-wait AHB-Lite slave, word accesses, synchronous pins
// Notes:   Active options change only by a reset; store by programming or erase
//
// Behaviour
// - Enabled watchdog resets device on timeout while the pin is normal.
// - Watchdog option clear disables watchdog regardless of pin voltage.
// - Sensitivity clear: interrupt pin reacts to falling edges only.
// - Sensitivity set: interrupt pin reacts to falling edge and low level.
// - Bit-order option set shifts serial data LSB first, else MSB first.
// - Rate codes 00..11 divide the oscillator by 64, 32, 16, 8.
// - Stop-behaviour set: stop keeps oscillator running, enters halt.
// - Stop-behaviour clear: stop halts oscillator, enters stop mode.
// - Security option set locks program memory against read-out.
// - Each port A option bit enables its pin's pull-up and interrupt.
// - Port A interrupts use the same edge or level sensitivity.
// - Options live in two bytes of nonvolatile storage.
// - In bootloader mode every option bit is writable and readable; here option byte reads return 00 while the latch bit is set.
// - Newly programmed options take effect only after the next reset.
// - Option bytes sit at addresses 1EFF and 1F00; here these are word indices, so byte addresses 7BFC and 7C00.
// - Setting both bits leaves only latch; clearing latch clears voltage.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ocl_top #(
    parameter int PROG_CYCLES = ocl_pkg::PROGRAM_CYCLES,
    parameter int WATCHDOG_CYCLES = ocl_pkg::WATCHDOG_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [15:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic boot_mode,
    input wire logic nv_erase,
    input wire logic programming_voltage_on,
    input wire logic irq_pin_in_logic_range,
    input wire logic irq_n,
    input wire logic [7:0] porta_n,
    input wire logic stop_exec,
    input wire logic wake_event,
    output logic watchdog_enable,
    output logic watchdog_reset_req,
    output logic ext_irq_req,
    output logic [7:0] porta_irq_req,
    output logic [7:0] porta_pullup_irq_enable,
    output logic serial_bit_order_select,
    output logic [6:0] serial_div_ratio,
    output logic serial_clk_tick,
    output logic osc_run,
    output logic halt_mode,
    output logic stop_mode,
    output logic readout_lock
);

    typedef struct packed {
        logic dph_v;
        logic dph_wr;
        logic [13:0] dph_idx;
        logic [31:0] rdata;
        logic program_latch_bit;
        logic program_voltage_bit;
        logic loaded;
        logic [7:0] opt_one;
        logic [7:0] opt_two;
        logic [31:0] wdog_cnt;
        logic wdog_fire;
        ocl_pkg::ocl_pwr_e pwr;
        logic [6:0] div_cnt;
        logic sclk_tick;
    } ocl_top_s;

    ocl_top_s st_q;
    ocl_top_s st_d;
    logic [7:0] nv_one;
    logic [7:0] nv_two;
    logic nv_pending;
    logic nv_busy;
    logic wr_en;
    logic nv_capture;
    logic [6:0] ratio;
    logic [7:0] rd_opt;

    // ------------------------------------------------------------
    // Option storage and interrupt sensing
    // ------------------------------------------------------------
    ocl_nv_store #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_store (
        .hclk(hclk),
        .hresetn(hresetn),
        .nv_erase(nv_erase),
        .capture(nv_capture),
        .capture_sel_two(st_q.dph_idx == ocl_pkg::IDX_OPTION_BYTE_TWO),
        .capture_data(hwdata[7:0]),
        .latch_on(st_q.program_latch_bit),
        .prog_on(st_q.program_voltage_bit & programming_voltage_on),
        .byte_one(nv_one),
        .byte_two(nv_two),
        .pending(nv_pending),
        .busy(nv_busy)
    );

    ocl_irq_sense #(
        .WIDTH(1)
    ) u_ext_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_n(irq_n),
        .enable(1'b1),
        .level_mode(st_q.opt_one[ocl_pkg::OPT_LEVEL_BIT]),
        .req(ext_irq_req)
    );

    ocl_irq_sense #(
        .WIDTH(8)
    ) u_porta_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_n(porta_n),
        .enable(st_q.opt_two),
        .level_mode(st_q.opt_one[ocl_pkg::OPT_LEVEL_BIT]),
        .req(porta_irq_req)
    );

    // ------------------------------------------------------------
    // Bus decode and register effects
    // ------------------------------------------------------------
    assign wr_en = st_q.dph_v & st_q.dph_wr;
    assign nv_capture = wr_en & boot_mode & st_q.program_latch_bit &
        ((st_q.dph_idx == ocl_pkg::IDX_OPTION_BYTE_ONE) |
         (st_q.dph_idx == ocl_pkg::IDX_OPTION_BYTE_TWO));

    always_comb begin
        case ({st_q.opt_one[ocl_pkg::OPT_RATE_HIGH_BIT],
               st_q.opt_one[ocl_pkg::OPT_RATE_LOW_BIT]})
            2'b00: ratio = ocl_pkg::DIV_RATE_00;
            2'b01: ratio = ocl_pkg::DIV_RATE_01;
            2'b10: ratio = ocl_pkg::DIV_RATE_10;
            2'b11: ratio = ocl_pkg::DIV_RATE_11;
            default: ratio = ocl_pkg::DIV_RATE_00;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.wdog_fire = 1'b0;
        st_d.sclk_tick = 1'b0;
        rd_opt = ocl_pkg::OPT_ERASED;

        // Control bits move only under bootloader mode
        if (wr_en && boot_mode &&
            st_q.dph_idx == ocl_pkg::IDX_PROGRAM_CONTROL) begin
            st_d.program_latch_bit = hwdata[ocl_pkg::PC_LATCH_BIT];
            st_d.program_voltage_bit = hwdata[ocl_pkg::PC_VOLTAGE_BIT] &
                hwdata[ocl_pkg::PC_LATCH_BIT] &
                st_q.program_latch_bit;
        end

        // One copy per reset; the store may be reprogrammed meanwhile
        if (!st_q.loaded) begin
            st_d.opt_one = nv_one;
            st_d.opt_two = nv_two;
            st_d.loaded = 1'b1;
        end

        if (!st_q.opt_one[ocl_pkg::OPT_WATCHDOG_BIT]) begin
            st_d.wdog_cnt = '0;
        end else if (wr_en &&
                     st_q.dph_idx == ocl_pkg::IDX_WATCHDOG_SERVICE) begin
            st_d.wdog_cnt = '0;
        end else if (irq_pin_in_logic_range) begin
            if (st_q.wdog_cnt == 32'(WATCHDOG_CYCLES - 1)) begin
                st_d.wdog_cnt = '0;
                st_d.wdog_fire = 1'b1;
            end else begin
                st_d.wdog_cnt = st_q.wdog_cnt + 32'h0000_0001;
            end
        end

        case (st_q.pwr)
            ocl_pkg::OCL_RUN: begin
                if (stop_exec) begin
                    if (st_q.opt_one[ocl_pkg::OPT_STOP_OSC_BIT]) begin
                        st_d.pwr = ocl_pkg::OCL_HALT;
                    end else begin
                        st_d.pwr = ocl_pkg::OCL_STOP;
                    end
                end
            end
            ocl_pkg::OCL_HALT, ocl_pkg::OCL_STOP: begin
                if (wake_event) begin
                    st_d.pwr = ocl_pkg::OCL_RUN;
                end
            end
            default: st_d.pwr = ocl_pkg::OCL_RUN;
        endcase

        if (st_q.div_cnt >= ratio - 7'h01) begin
            st_d.div_cnt = '0;
            st_d.sclk_tick = 1'b1;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 7'h01;
        end

        // Address phase: capture and prepare read data from next state
        st_d.dph_v = hsel & hready & (htrans == ocl_pkg::HTRANS_NONSEQ);
        st_d.dph_wr = hwrite;
        st_d.dph_idx = haddr[15:2];
        if (st_d.program_latch_bit) begin
            rd_opt = ocl_pkg::OPT_ERASED;
        end else if (boot_mode) begin
            rd_opt = (haddr[15:2] == ocl_pkg::IDX_OPTION_BYTE_TWO) ?
                nv_two : nv_one;
        end else begin
            rd_opt = (haddr[15:2] == ocl_pkg::IDX_OPTION_BYTE_TWO) ?
                st_d.opt_two : st_d.opt_one;
        end
        st_d.rdata = ocl_pkg::WORD_ZERO;
        if (st_d.dph_v && !hwrite) begin
            case (haddr[15:2])
                ocl_pkg::IDX_PROGRAM_CONTROL: begin
                    st_d.rdata[ocl_pkg::PC_LATCH_BIT] =
                        st_d.program_latch_bit;
                    st_d.rdata[ocl_pkg::PC_VOLTAGE_BIT] =
                        st_d.program_voltage_bit;
                end
                ocl_pkg::IDX_OPTION_BYTE_ONE,
                ocl_pkg::IDX_OPTION_BYTE_TWO: st_d.rdata[7:0] = rd_opt;
                ocl_pkg::IDX_ACTIVE_OPTIONS: begin
                    st_d.rdata[15:0] = {st_d.opt_two, st_d.opt_one};
                end
                ocl_pkg::IDX_LOADER_STATUS: begin
                    st_d.rdata[ocl_pkg::ST_LOADED_BIT] = st_d.loaded;
                    st_d.rdata[ocl_pkg::ST_PENDING_BIT] = nv_pending;
                    st_d.rdata[ocl_pkg::ST_BUSY_BIT] = nv_busy;
                    st_d.rdata[ocl_pkg::ST_HALT_BIT] =
                        (st_d.pwr == ocl_pkg::OCL_HALT);
                    st_d.rdata[ocl_pkg::ST_STOP_BIT] =
                        (st_d.pwr == ocl_pkg::OCL_STOP);
                end
                default: st_d.rdata = ocl_pkg::WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{
                dph_v: 1'b0, dph_wr: 1'b0, dph_idx: '0,
                rdata: ocl_pkg::WORD_ZERO,
                program_latch_bit: 1'b0, program_voltage_bit: 1'b0,
                loaded: 1'b0,
                opt_one: ocl_pkg::OPT_ERASED, opt_two: ocl_pkg::OPT_ERASED,
                wdog_cnt: '0, wdog_fire: 1'b0, pwr: ocl_pkg::OCL_RUN,
                div_cnt: '0, sclk_tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;
    assign watchdog_enable = st_q.opt_one[ocl_pkg::OPT_WATCHDOG_BIT];
    assign watchdog_reset_req = st_q.wdog_fire;
    assign porta_pullup_irq_enable = st_q.opt_two;
    assign serial_bit_order_select =
        st_q.opt_one[ocl_pkg::OPT_LSB_FIRST_BIT];
    assign serial_div_ratio = ratio;
    assign serial_clk_tick = st_q.sclk_tick;
    assign osc_run = (st_q.pwr != ocl_pkg::OCL_STOP);
    assign halt_mode = (st_q.pwr == ocl_pkg::OCL_HALT);
    assign stop_mode = (st_q.pwr == ocl_pkg::OCL_STOP);
    assign readout_lock = st_q.opt_one[ocl_pkg::OPT_SECURE_BIT];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_both_bits;
        @(posedge hclk) disable iff (!hresetn)
        (wr_en && boot_mode && !st_q.program_latch_bit &&
         st_q.dph_idx == ocl_pkg::IDX_PROGRAM_CONTROL &&
         hwdata[ocl_pkg::PC_LATCH_BIT] && hwdata[ocl_pkg::PC_VOLTAGE_BIT])
        |=> (st_q.program_latch_bit && !st_q.program_voltage_bit);
    endproperty
    a_both_bits: assert property (p_both_bits)
        else $error("latch and voltage set by one write");

    property p_voltage_needs_latch;
        @(posedge hclk) disable iff (!hresetn)
        !st_q.program_latch_bit |-> !st_q.program_voltage_bit;
    endproperty
    a_voltage_needs_latch: assert property (p_voltage_needs_latch)
        else $error("voltage bit set without latch bit");

    property p_wdog_off;
        @(posedge hclk) disable iff (!hresetn)
        !watchdog_enable |=> !watchdog_reset_req;
    endproperty
    a_wdog_off: assert property (p_wdog_off)
        else $error("disabled watchdog requested reset");

    property p_wdog_cause;
        @(posedge hclk) disable iff (!hresetn)
        watchdog_reset_req |->
            ($past(watchdog_enable) && $past(irq_pin_in_logic_range) &&
             $past(st_q.wdog_cnt) == 32'(WATCHDOG_CYCLES - 1));
    endproperty
    a_wdog_cause: assert property (p_wdog_cause)
        else $error("watchdog reset without timeout");

    property p_load;
        @(posedge hclk) disable iff (!hresetn)
        $rose(st_q.loaded) |->
            (st_q.opt_one == $past(nv_one) && st_q.opt_two == $past(nv_two));
    endproperty
    a_load: assert property (p_load)
        else $error("active options differ from store at load");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        $past(st_q.loaded) |->
            ($stable(st_q.opt_one) && $stable(st_q.opt_two));
    endproperty
    a_hold: assert property (p_hold)
        else $error("active options changed without reset");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        (stop_exec && st_q.pwr == ocl_pkg::OCL_RUN &&
         st_q.opt_one[ocl_pkg::OPT_STOP_OSC_BIT]) |=> (halt_mode && osc_run);
    endproperty
    a_halt: assert property (p_halt)
        else $error("stop did not enter halt with oscillator on");

    property p_stop;
        @(posedge hclk) disable iff (!hresetn)
        (stop_exec && st_q.pwr == ocl_pkg::OCL_RUN &&
         !st_q.opt_one[ocl_pkg::OPT_STOP_OSC_BIT]) |=> (stop_mode && !osc_run);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not halt the oscillator");

endmodule : ocl_top
